// ==== rtl/cpone_pkg.sv ====
// Register map, field positions and reset values for the comparator control
package cpone_pkg;

	localparam logic [7:0] CPONE_CTRL_ADDR  = 8'h9A;
	localparam logic [7:0] CPONE_MODE_ADDR  = 8'h9C;
	localparam logic [7:0] CPONE_CTRL_RESET = 8'h00;
	localparam logic [7:0] CPONE_MODE_RESET = 8'h02;

	localparam int CPONE_EN_BIT    = 7;
	localparam int CPONE_STATE_BIT = 6;
	localparam int CPONE_RISE_BIT  = 5;
	localparam int CPONE_FALL_BIT  = 4;
	localparam int CPONE_HYP_LSB   = 2;
	localparam int CPONE_HYN_LSB   = 0;
	localparam int CPONE_RSVD_BIT  = 7;
	localparam int CPONE_RIE_BIT   = 5;
	localparam int CPONE_FIE_BIT   = 4;
	localparam int CPONE_MD_LSB    = 0;

	localparam logic [1:0] CPONE_HYST_OFF  = 2'h0;
	localparam logic [1:0] CPONE_HYST_LOW  = 2'h1;
	localparam logic [1:0] CPONE_HYST_MID  = 2'h2;
	localparam logic [1:0] CPONE_HYST_HIGH = 2'h3;

	localparam logic [4:0] CPONE_MV_OFF  = 5'h00;
	localparam logic [4:0] CPONE_MV_LOW  = 5'h05;
	localparam logic [4:0] CPONE_MV_MID  = 5'h0A;
	localparam logic [4:0] CPONE_MV_HIGH = 5'h14;

	localparam logic [1:0] CPONE_SPEED_FASTEST = 2'h0;
	localparam logic [1:0] CPONE_SPEED_LOWEST  = 2'h3;

	localparam int CPONE_SYNC_STAGES = 2;

endpackage

// ==== rtl/cpone_sync.sv ====
// Multi-stage synchroniser for the asynchronous comparator output
`timescale 1ns/1ps
module cpone_sync
	import cpone_pkg::*;
#(
	parameter int STAGES = CPONE_SYNC_STAGES
)
(
	input  wire logic clk_sys,
	input  wire logic reset,
	input  wire logic async_in,
	output logic      sync_out
);

	if (STAGES < 2)
	begin : g_bad_stages
		$error("cpone_sync needs at least two stages");
	end

	logic [STAGES-1:0] chain_r;
	logic [STAGES-1:0] chain_nxt;

	always_comb
	begin
		chain_nxt = {chain_r[STAGES-2:0], async_in};
	end

	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
			chain_r <= '0;
		else
			chain_r <= chain_nxt;
	end

	assign sync_out = chain_r[STAGES-1];

endmodule

// ==== rtl/cpone_edge_flag.sv ====
// Sticky edge flag with write-zero clear; a new edge beats the clear
`timescale 1ns/1ps
module cpone_edge_flag
	import cpone_pkg::*;
#(
	parameter logic RISING = 1'b1
)
(
	input  wire logic clk_sys,
	input  wire logic reset,
	input  wire logic level,
	input  wire logic arm,
	input  wire logic clear,
	output logic      flag
);

	logic prev_r;
	logic flag_r;
	logic prev_nxt;
	logic flag_nxt;
	logic hit;

	always_comb
	begin
		prev_nxt = level;
		hit = arm && (RISING ? (level && !prev_r) : (!level && prev_r));
		flag_nxt = hit || (flag_r && !clear);
	end

	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			prev_r <= 1'b0;
			flag_r <= 1'b0;
		end
		else
		begin
			prev_r <= prev_nxt;
			flag_r <= flag_nxt;
		end
	end

	assign flag = flag_r;

endmodule

// ==== rtl/cpone_ctrl.sv ====
// Control and status registers of the second comparator
`timescale 1ns/1ps
module cpone_ctrl
	import cpone_pkg::*;
#(
	parameter int SYNC_STAGES = CPONE_SYNC_STAGES
)
(
	input  wire logic       clk_sys,
	input  wire logic       reset,
	input  wire logic [7:0] sfr_addr,
	input  wire logic       sfr_wr,
	input  wire logic [7:0] sfr_wdata,
	output logic      [7:0] sfr_rdata,
	input  wire logic       cmp_raw,
	output logic            cmp_enable,
	output logic      [1:0] cmp_speed_power_mode,
	output logic      [1:0] cmp_pos_hysteresis,
	output logic      [1:0] cmp_neg_hysteresis,
	output logic      [4:0] cmp_pos_hyst_mv,
	output logic      [4:0] cmp_neg_hyst_mv,
	output logic            irq_req
);

	if (SYNC_STAGES < 2)
	begin : g_bad_sync
		$error("cpone_ctrl needs at least two sync stages");
	end

	// Hysteresis code to millivolts, shared by both directions
	function automatic logic [4:0] hyst_mv(input logic [1:0] code);
		logic [4:0] mv;
		mv = CPONE_MV_OFF;
		unique case (code)
			CPONE_HYST_OFF:  mv = CPONE_MV_OFF;
			CPONE_HYST_LOW:  mv = CPONE_MV_LOW;
			CPONE_HYST_MID:  mv = CPONE_MV_MID;
			CPONE_HYST_HIGH: mv = CPONE_MV_HIGH;
		endcase
		return mv;
	endfunction

	logic       wr_ctrl;
	logic       wr_mode;
	logic       en_r;
	logic       en_nxt;
	logic [1:0] hyp_r;
	logic [1:0] hyp_nxt;
	logic [1:0] hyn_r;
	logic [1:0] hyn_nxt;
	logic       rie_r;
	logic       rie_nxt;
	logic       fie_r;
	logic       fie_nxt;
	logic [1:0] md_r;
	logic [1:0] md_nxt;
	logic [4:0] pos_mv_r;
	logic [4:0] pos_mv_nxt;
	logic [4:0] neg_mv_r;
	logic [4:0] neg_mv_nxt;
	logic       cmp_sync;
	logic       state_r;
	logic       state_nxt;
	logic       rise_flag;
	logic       fall_flag;
	logic       rise_clear;
	logic       fall_clear;
	logic [7:0] rdata_r;
	logic [7:0] rdata_nxt;
	logic       irq_r;
	logic       irq_nxt;

	assign wr_ctrl = sfr_wr && (sfr_addr == CPONE_CTRL_ADDR);
	assign wr_mode = sfr_wr && (sfr_addr == CPONE_MODE_ADDR);

	// Configuration fields
	always_comb
	begin
		en_nxt  = en_r;
		hyp_nxt = hyp_r;
		hyn_nxt = hyn_r;
		rie_nxt = rie_r;
		fie_nxt = fie_r;
		md_nxt  = md_r;
		if (wr_ctrl)
		begin
			en_nxt  = sfr_wdata[CPONE_EN_BIT];
			hyp_nxt = sfr_wdata[CPONE_HYP_LSB +: 2];
			hyn_nxt = sfr_wdata[CPONE_HYN_LSB +: 2];
		end
		if (wr_mode)
		begin
			rie_nxt = sfr_wdata[CPONE_RIE_BIT];
			fie_nxt = sfr_wdata[CPONE_FIE_BIT];
			md_nxt  = sfr_wdata[CPONE_MD_LSB +: 2];
		end
		pos_mv_nxt = hyst_mv(hyp_r);
		neg_mv_nxt = hyst_mv(hyn_r);
	end

	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			en_r     <= CPONE_CTRL_RESET[CPONE_EN_BIT];
			hyp_r    <= CPONE_CTRL_RESET[CPONE_HYP_LSB +: 2];
			hyn_r    <= CPONE_CTRL_RESET[CPONE_HYN_LSB +: 2];
			rie_r    <= CPONE_MODE_RESET[CPONE_RIE_BIT];
			fie_r    <= CPONE_MODE_RESET[CPONE_FIE_BIT];
			md_r     <= CPONE_MODE_RESET[CPONE_MD_LSB +: 2];
			pos_mv_r <= CPONE_MV_OFF;
			neg_mv_r <= CPONE_MV_OFF;
		end
		else
		begin
			en_r     <= en_nxt;
			hyp_r    <= hyp_nxt;
			hyn_r    <= hyn_nxt;
			rie_r    <= rie_nxt;
			fie_r    <= fie_nxt;
			md_r     <= md_nxt;
			pos_mv_r <= pos_mv_nxt;
			neg_mv_r <= neg_mv_nxt;
		end
	end

	// Analog output arrives with no relation to clk_sys
	cpone_sync #(
		.STAGES   (SYNC_STAGES)
	) u_sync (
		.clk_sys  (clk_sys),
		.reset    (reset),
		.async_in (cmp_raw),
		.sync_out (cmp_sync)
	);

	// flags clear only on a written zero
	assign rise_clear = wr_ctrl && !sfr_wdata[CPONE_RISE_BIT];
	assign fall_clear = wr_ctrl && !sfr_wdata[CPONE_FALL_BIT];

	cpone_edge_flag #(
		.RISING  (1'b1)
	) u_rise (
		.clk_sys (clk_sys),
		.reset   (reset),
		.level   (state_r),
		.arm     (en_r),
		.clear   (rise_clear),
		.flag    (rise_flag)
	);

	cpone_edge_flag #(
		.RISING  (1'b0)
	) u_fall (
		.clk_sys (clk_sys),
		.reset   (reset),
		.level   (state_r),
		.arm     (en_r),
		.clear   (fall_clear),
		.flag    (fall_flag)
	);

	// Status, read data and request
	always_comb
	begin
		// state reads low while powered down
		state_nxt = cmp_sync && en_r;
		irq_nxt = (rise_flag && rie_r) || (fall_flag && fie_r);
		rdata_nxt = 8'h00;
		if (sfr_addr == CPONE_CTRL_ADDR)
		begin
			rdata_nxt[CPONE_EN_BIT]        = en_r;
			rdata_nxt[CPONE_STATE_BIT]     = state_r;
			rdata_nxt[CPONE_RISE_BIT]      = rise_flag;
			rdata_nxt[CPONE_FALL_BIT]      = fall_flag;
			rdata_nxt[CPONE_HYP_LSB +: 2]  = hyp_r;
			rdata_nxt[CPONE_HYN_LSB +: 2]  = hyn_r;
		end
		else if (sfr_addr == CPONE_MODE_ADDR)
		begin
			rdata_nxt[CPONE_RIE_BIT]     = rie_r;
			rdata_nxt[CPONE_FIE_BIT]     = fie_r;
			rdata_nxt[CPONE_MD_LSB +: 2] = md_r;
		end
	end

	// Read data lags the address by one clock
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			state_r <= 1'b0;
			irq_r   <= 1'b0;
			rdata_r <= 8'h00;
		end
		else
		begin
			state_r <= state_nxt;
			irq_r   <= irq_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	assign sfr_rdata            = rdata_r;
	assign cmp_enable           = en_r;
	assign cmp_speed_power_mode = md_r;
	assign cmp_pos_hysteresis   = hyp_r;
	assign cmp_neg_hysteresis   = hyn_r;
	assign cmp_pos_hyst_mv      = pos_mv_r;
	assign cmp_neg_hyst_mv      = neg_mv_r;
	assign irq_req              = irq_r;

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (reset);

	sequence s_ctrl_write_high_hyp;
		wr_ctrl && (sfr_wdata[CPONE_HYP_LSB +: 2] == CPONE_HYST_HIGH);
	endsequence

	sequence s_ctrl_write_low_hyn;
		wr_ctrl && (sfr_wdata[CPONE_HYN_LSB +: 2] == CPONE_HYST_LOW);
	endsequence

	sequence s_input_high_held;
		(en_r && cmp_raw) [*4];
	endsequence

	a_enable_write: assert property (
		wr_ctrl |=> cmp_enable == $past(sfr_wdata[CPONE_EN_BIT]))
		else $error("enable did not follow control write");

	a_state_tracks: assert property (
		s_input_high_held |=> state_r)
		else $error("state bit missed a steady high input");

	a_state_off: assert property (
		!en_r |=> !state_r)
		else $error("state bit high while disabled");

	a_rise_sets: assert property (
		$rose(state_r) && en_r |=> rise_flag)
		else $error("rising edge did not set flag");

	a_rise_holds: assert property (
		rise_flag && !rise_clear |=> rise_flag)
		else $error("rising flag dropped without a clear");

	a_fall_sets: assert property (
		$fell(state_r) && en_r |=> fall_flag)
		else $error("falling edge did not set flag");

	a_fall_clears: assert property (
		fall_clear && !($fell(state_r) && en_r) |=> !fall_flag)
		else $error("falling flag survived a zero write");

	a_rise_gate_on: assert property (
		rise_flag && rie_r |=> irq_req)
		else $error("enabled rising flag gave no request");

	a_fall_gate_on: assert property (
		fall_flag && fie_r |=> irq_req)
		else $error("enabled falling flag gave no request");

	a_rise_clears: assert property (
		rise_clear && !($rose(state_r) && en_r) |=> !rise_flag)
		else $error("rising flag survived a zero write");

	a_rise_gate_off: assert property (
		!(rise_flag && rie_r) && !(fall_flag && fie_r) |=> !irq_req)
		else $error("request without an enabled flag");

	a_mode_write: assert property (
		wr_mode |=> cmp_speed_power_mode == $past(sfr_wdata[1:0]))
		else $error("speed mode did not follow write");

	a_pos_hyst: assert property (
		s_ctrl_write_high_hyp |=> ##1 cmp_pos_hyst_mv == CPONE_MV_HIGH)
		else $error("positive hysteresis decode wrong");

	a_neg_hyst: assert property (
		s_ctrl_write_low_hyn |=> ##1 cmp_neg_hyst_mv == CPONE_MV_LOW)
		else $error("negative hysteresis decode wrong");

	a_mode_zero_bits: assert property (
		sfr_addr == CPONE_MODE_ADDR |=>
			sfr_rdata[7:6] == 2'h0 && sfr_rdata[3:2] == 2'h0)
		else $error("mode reserved or unused bits read nonzero");

endmodule

// ==== verification/cpone_cmp_model.sv ====
// Behavioural analog comparator core facing the control block
`timescale 1ns/1ps
module cpone_cmp_model
(
	input  wire logic               clk_sys,
	input  wire logic               cmp_enable,
	input  wire logic         [4:0] cmp_pos_hyst_mv,
	input  wire logic         [4:0] cmp_neg_hyst_mv,
	input  wire logic signed [15:0] pos_mv,
	input  wire logic signed [15:0] neg_mv,
	output logic                    cmp_raw
);
	logic out_r = 1'b0;

	// Unpowered core gives junk, so toggle every cycle
	always @(posedge clk_sys)
		if (!cmp_enable)
			out_r <= ~out_r;
		else if (pos_mv - neg_mv > signed'({11'h000, cmp_pos_hyst_mv}))
			out_r <= 1'b1;
		else if (neg_mv - pos_mv > signed'({11'h000, cmp_neg_hyst_mv}))
			out_r <= 1'b0;

	assign cmp_raw = out_r;
endmodule

// ==== verification/testbench.sv ====
// Self-checking bench for the comparator control registers
`timescale 1ns/1ps
module testbench;
	import cpone_pkg::*;
	logic               clk_sys   = 1'b0;
	logic               reset     = 1'b1;
	logic         [7:0] sfr_addr  = 8'h00;
	logic               sfr_wr    = 1'b0;
	logic         [7:0] sfr_wdata = 8'h00;
	logic         [7:0] sfr_rdata;
	logic               cmp_raw;
	logic               cmp_enable;
	logic               irq_req;
	logic         [1:0] cmp_speed_power_mode;
	logic         [1:0] cmp_pos_hysteresis;
	logic         [1:0] cmp_neg_hysteresis;
	logic         [4:0] cmp_pos_hyst_mv;
	logic         [4:0] cmp_neg_hyst_mv;
	logic signed [15:0] pos_mv    = 16'sh0000;
	logic signed [15:0] neg_mv    = 16'sh0000;
	logic         [7:0] w;
	int                 n_errors  = 0;
	int                 num_checks = 0;

	always #5 clk_sys = ~clk_sys;

	cpone_ctrl cpone_ctrl_i (.clk_sys, .reset, .sfr_addr, .sfr_wr,
		.sfr_wdata, .sfr_rdata, .cmp_raw, .cmp_enable,
		.cmp_speed_power_mode, .cmp_pos_hysteresis, .cmp_neg_hysteresis,
		.cmp_pos_hyst_mv, .cmp_neg_hyst_mv, .irq_req);

	cpone_cmp_model cpone_cmp_model_i (.clk_sys, .cmp_enable,
		.cmp_pos_hyst_mv, .cmp_neg_hyst_mv, .pos_mv, .neg_mv, .cmp_raw);

	function automatic logic [4:0] mv_of(input logic [1:0] c);
		return c == 2'h0 ? 5'h00 : c == 2'h1 ? 5'h05 :
			c == 2'h2 ? 5'h0A : 5'h14;
	endfunction

	task automatic stop_test;
		if (n_errors == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			n_errors++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_sys);
		sfr_addr = a;
		sfr_wr = 1'b1;
		sfr_wdata = d;
		@(negedge clk_sys);
		sfr_wr = 1'b0;
	endtask

	task automatic chk_reg(input logic [7:0] a, input logic [7:0] exp);
		@(negedge clk_sys);
		sfr_addr = a;
		repeat (2) @(negedge clk_sys);
		chk_val(sfr_rdata, exp);
	endtask

	// Bounded wait for a raised request
	task automatic wait_irq;
		int k;
		k = 0;
		while (irq_req !== 1'b1 && k < 20)
		begin
			@(negedge clk_sys);
			k++;
		end
		chk_val({7'h00, irq_req}, 8'h01);
		if (irq_req !== 1'b1)
			stop_test;
	endtask

	task automatic settle;
		repeat (8) @(negedge clk_sys);
	endtask

	initial
	begin
		void'($urandom(23));
		repeat (4) @(negedge clk_sys);
		reset = 1'b0;
		chk_reg(8'h9A, 8'h00);
		chk_reg(8'h9C, 8'h02);
		chk_reg(8'h55, 8'h00);
		chk_val({6'h00, cmp_speed_power_mode}, 8'h02);
		for (int i = 0; i < 8; i++)
		begin
			// software keeps the reserved bit at zero
			w = {1'b0, 7'($urandom)};
			if (i < 4)
				w[1:0] = i[1:0];
			wr(8'h9C, w);
			chk_reg(8'h9C, w & 8'h33);
			chk_val({6'h00, cmp_speed_power_mode}, {6'h00, w[1:0]});
		end
		// Disabled core toggles, state must still read zero
		for (int i = 0; i < 16; i++)
		begin
			wr(8'h9A, 8'(i));
			chk_reg(8'h9A, 8'(i));
			chk_val({3'h0, cmp_pos_hyst_mv}, {3'h0, mv_of(i[3:2])});
			chk_val({3'h0, cmp_neg_hyst_mv}, {3'h0, mv_of(i[1:0])});
			chk_val({6'h00, cmp_pos_hysteresis}, {6'h00, i[3:2]});
			chk_val({6'h00, cmp_neg_hysteresis}, {6'h00, i[1:0]});
		end
		neg_mv = 16'($urandom_range(500, 200));
		pos_mv = neg_mv - 16'sd40;
		wr(8'h9C, 8'h20);
		wr(8'h9A, 8'h80);
		settle;
		// Power-up junk may leave flags, so clear them first
		wr(8'h9A, 8'h80);
		chk_reg(8'h9A, 8'h80);
		chk_val({7'h00, cmp_enable}, 8'h01);
		pos_mv = neg_mv + 16'sd40;
		wait_irq;
		chk_reg(8'h9A, 8'hE0);
		wr(8'h9A, 8'hB0);
		chk_reg(8'h9A, 8'hE0);
		wr(8'h9A, 8'h80);
		chk_reg(8'h9A, 8'hC0);
		chk_val({7'h00, irq_req}, 8'h00);
		pos_mv = neg_mv - 16'sd40;
		settle;
		chk_reg(8'h9A, 8'h90);
		chk_val({7'h00, irq_req}, 8'h00);
		wr(8'h9C, 8'h10);
		wait_irq;
		wr(8'h9C, 8'h00);
		pos_mv = neg_mv + 16'sd40;
		settle;
		chk_reg(8'h9A, 8'hF0);
		chk_val({7'h00, irq_req}, 8'h00);
		wr(8'h9C, 8'h20);
		wait_irq;
		wr(8'h9A, 8'h00);
		settle;
		chk_reg(8'h9A, 8'h00);
		chk_val({7'h00, cmp_enable}, 8'h00);
		chk_val({7'h00, irq_req}, 8'h00);
		// Neighbour address must not touch the mode register
		wr(8'h9C, 8'h33);
		wr(8'h9D, 8'h00);
		chk_reg(8'h9C, 8'h33);
		wr(8'h9A, 8'h8F);
		settle;
		// Second reset in mid-run restores every reset value
		@(negedge clk_sys);
		reset = 1'b1;
		repeat (2) @(negedge clk_sys);
		reset = 1'b0;
		chk_val({7'h00, cmp_enable}, 8'h00);
		chk_val({6'h00, cmp_speed_power_mode}, 8'h02);
		chk_val({3'h0, cmp_pos_hyst_mv}, 8'h00);
		chk_val({3'h0, cmp_neg_hyst_mv}, 8'h00);
		chk_val({7'h00, irq_req}, 8'h00);
		chk_reg(8'h9C, 8'h02);
		chk_reg(8'h9A, 8'h00);
		stop_test;
	end
endmodule
